/* iskp_exec.sv */
// Execution stage for increment-and-skip and test-and-skip instructions.
// Assumes decode presents a one-cycle op pulse with the memory operand,
// and that fetch obeys the skip output by discarding the next word.
// Assumes data memory takes mem_we, mem_waddr and mem_wdata one cycle late,
// and that the flag logic elsewhere treats flags_we as its write strobe.
// Function
// - Memory increment-skip adds one and writes result back to same byte.
// - Zero result suppresses the next instruction; nonzero continues.
// - A taken skip inserts a dummy cycle; instruction takes two cycles.
// - Accumulator variant stores increment in accumulator, memory unchanged.
// - Accumulator variant skips when new accumulator is zero, same way.
// - Nonzero test skips next instruction when operand nonzero, two cycles.
module iskp_exec #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire iskp_pkg::iskp_op_e op,
  input wire logic [WIDTH-1:0] mem_rdata,
  input wire logic [7:0] mem_addr,
  output logic mem_we,
  output logic [7:0] mem_waddr,
  output logic [WIDTH-1:0] mem_wdata,
  output logic [WIDTH-1:0] accumulator_reg,
  output logic skip_next,
  output logic dummy_cycle,
  output logic busy,
  output logic flags_we
);
  import iskp_pkg::*;

  typedef enum logic {ISKP_RUN, ISKP_DUMMY} iskp_state_e;
  iskp_state_e state_reg;
  iskp_state_e state_next;

  logic [WIDTH-1:0] inc_val;
  logic inc_zero;
  logic opnd_nz;

  iskp_alu #(.WIDTH(WIDTH)) u_alu (
    .operand(mem_rdata),
    .incremented(inc_val),
    .inc_is_zero(inc_zero),
    .opnd_nonzero(opnd_nz)
  );

  // Decode one op code; a slot that is not accepted decodes as nothing
  function automatic logic op_hit(input iskp_op_e code, input iskp_op_e want,
    input logic ok);
    return ok && (code == want);
  endfunction : op_hit

  // Ops are ignored in the dummy cycle: that slot belongs to the skipped word
  wire accept = (state_reg == ISKP_RUN);
  wire is_mem = op_hit(op, ISKP_OP_INCR_MEM_SKIP_ZERO, accept);
  wire is_acc = op_hit(op, ISKP_OP_INCR_TO_ACC_SKIP_ZERO, accept);
  wire is_tst = op_hit(op, ISKP_OP_SKIP_IF_NONZERO_TEST, accept);
  wire take_skip = ((is_mem || is_acc) && inc_zero)
                   || (is_tst && opnd_nz);

  // Dummy cycle follows any taken skip, then back to normal run
  always_comb begin
    state_next = ISKP_RUN;
    case (state_reg)
      ISKP_RUN: state_next = take_skip ? ISKP_DUMMY : ISKP_RUN;
      ISKP_DUMMY: state_next = ISKP_RUN;
      default: state_next = ISKP_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ISKP_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // A taken skip is followed by exactly one dummy cycle
  a_dummy_two: assert property (
    @(posedge mclk) disable iff (!nrst)
    take_skip |=> dummy_cycle ##1 !dummy_cycle)
    else $error("skip did not take exactly two cycles");

  // Without a skip the next cycle is an ordinary one
  a_one_cycle: assert property (
    @(posedge mclk) disable iff (!nrst)
    !take_skip |=> !dummy_cycle)
    else $error("dummy cycle without a taken skip");

  // The slot in the dummy cycle writes, skips and loads nothing
  a_dummy_ignores: assert property (
    @(posedge mclk) disable iff (!nrst)
    dummy_cycle |=> !skip_next && !mem_we && $stable(accumulator_reg))
    else $error("op in the dummy slot was executed");

  // Memory write port: only the memory variant writes, to the same address
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mem_we <= 1'b0;
      mem_waddr <= 8'h00;
      mem_wdata <= '0;
    end else begin
      mem_we <= is_mem;
      mem_waddr <= mem_addr;
      mem_wdata <= is_mem ? inc_val : mem_wdata;
    end
  end

  // A memory increment writes the wrapped sum one cycle later
  a_mem_write: assert property (
    @(posedge mclk) disable iff (!nrst)
    is_mem |=> mem_we && mem_wdata == $past(mem_rdata) + INC_STEP)
    else $error("memory increment not written back");

  // The write goes to the operand's own address
  a_mem_addr: assert property (
    @(posedge mclk) disable iff (!nrst)
    is_mem |=> mem_waddr == $past(mem_addr))
    else $error("write address differs from operand address");

  // Write data only moves for a memory increment
  a_wdata_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    !is_mem |=> $stable(mem_wdata))
    else $error("write data changed without a memory increment");

  // No other op, the accumulator variant included, writes memory
  a_we_only_mem: assert property (
    @(posedge mclk) disable iff (!nrst)
    !is_mem |=> !mem_we)
    else $error("memory written by a non-memory op");

  // Accumulator takes the increment only for the accumulator variant
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      accumulator_reg <= WIDTH'(ACC_RESET);
    end else if (is_acc) begin
      accumulator_reg <= inc_val;
    end
  end

  // Accumulator variant loads the sum and leaves memory alone
  a_acc_nomem: assert property (
    @(posedge mclk) disable iff (!nrst)
    is_acc |=> !mem_we && accumulator_reg == $past(mem_rdata) + INC_STEP)
    else $error("accumulator variant wrong");

  // Only the accumulator variant changes the accumulator
  a_acc_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    !is_acc |=> $stable(accumulator_reg))
    else $error("accumulator changed by another op");

  // The nonzero test leaves accumulator and memory as they were
  a_tst_keeps: assert property (
    @(posedge mclk) disable iff (!nrst)
    is_tst |=> $stable(accumulator_reg) && !mem_we)
    else $error("nonzero test changed a result");

  // Skip and dummy indicators for fetch; flags are never written
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      skip_next <= 1'b0;
      dummy_cycle <= 1'b0;
      busy <= 1'b0;
      flags_we <= 1'b0;
    end else begin
      skip_next <= take_skip;
      dummy_cycle <= (state_next == ISKP_DUMMY);
      busy <= (state_next == ISKP_DUMMY);
      flags_we <= 1'b0;
    end
  end

  // Skip only when the incremented value wraps to zero
  a_skip_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    (is_mem || is_acc) |=>
      skip_next == ($past(mem_rdata) + INC_STEP == ZERO_VAL))
    else $error("skip not tied to zero result");

  // A nonzero increment lets the program run on in one cycle
  a_nonzero_go: assert property (
    @(posedge mclk) disable iff (!nrst)
    (is_mem || is_acc) && mem_rdata + INC_STEP != ZERO_VAL |=> !dummy_cycle)
    else $error("dummy cycle after a nonzero increment");

  // Accumulator variant skips exactly when the new accumulator is zero
  a_acc_skip: assert property (
    @(posedge mclk) disable iff (!nrst)
    is_acc |=> skip_next == (accumulator_reg == ZERO_VAL))
    else $error("accumulator skip mismatch");

  // Nonzero test skips on a nonzero operand and writes nothing
  a_test_skip: assert property (
    @(posedge mclk) disable iff (!nrst)
    is_tst |=> skip_next == ($past(mem_rdata) != ZERO_VAL) && !mem_we)
    else $error("nonzero test skip mismatch");

  // A zero operand lets the nonzero test run on in one cycle
  a_test_go: assert property (
    @(posedge mclk) disable iff (!nrst)
    is_tst && mem_rdata == ZERO_VAL |=> !skip_next && !dummy_cycle)
    else $error("nonzero test skipped on a zero operand");

  // The skip indication is a single-cycle pulse
  a_skip_pulse: assert property (
    @(posedge mclk) disable iff (!nrst)
    skip_next |=> !skip_next)
    else $error("skip indication held too long");

  // Fetch sees skip and dummy cycle together
  a_skip_dummy: assert property (
    @(posedge mclk) disable iff (!nrst)
    skip_next == dummy_cycle)
    else $error("skip and dummy cycle out of step");

  // The flag write strobe never rises
  a_flags_quiet: assert property (
    @(posedge mclk) disable iff (!nrst)
    !flags_we)
    else $error("status flags written");
endmodule : iskp_exec

/* iskp_pkg.sv */
// Package for the increment-and-skip execution block.
// Assumes one core instruction clock and an 8-bit data path.
package iskp_pkg;
  localparam int DATA_W = 8;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] INC_STEP = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;
  localparam int SKIP_CYCLES = 2;

  // Operations this block executes
  typedef enum logic [1:0] {
    ISKP_OP_NONE,
    ISKP_OP_INCR_MEM_SKIP_ZERO,
    ISKP_OP_INCR_TO_ACC_SKIP_ZERO,
    ISKP_OP_SKIP_IF_NONZERO_TEST
  } iskp_op_e;
endpackage : iskp_pkg

/* iskp_alu.sv */
// Combinational incrementer and zero test for the skip instructions.
// Assumes the operand is the data memory byte read this cycle.
module iskp_alu #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] operand,
  output logic [WIDTH-1:0] incremented,
  output logic inc_is_zero,
  output logic opnd_nonzero
);
  // Increment wraps modulo the width, zero tests on both values
  assign incremented = operand + WIDTH'(1);
  assign inc_is_zero = (incremented == '0);
  assign opnd_nonzero = (operand != '0);
endmodule : iskp_alu

/* tb_top.sv */
// Self-checking bench for the increment-and-skip execution stage.
// Assumes the bench stands in for decode, fetch and data memory.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import iskp_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  iskp_op_e op = ISKP_OP_NONE;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] mem_addr = 8'h00;
  logic mem_we, skip_next, dummy_cycle, busy, flags_we;
  logic [7:0] mem_waddr, mem_wdata, accumulator_reg;
  logic [28:0] exp_q[$];
  logic [7:0] acc_m = ACC_RESET;
  logic skip_m = 1'b0;
  int error_cnt = 0;
  int checks = 0;
  iskp_exec #(.WIDTH(DATA_W)) dut (.mclk(mclk), .nrst(nrst), .op(op),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .accumulator_reg(accumulator_reg), .skip_next(skip_next),
    .dummy_cycle(dummy_cycle), .busy(busy), .flags_we(flags_we));
  // Clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  // One cycle of outputs against its note
  task automatic cmp(input logic [28:0] got, input logic [28:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Verdict and end of run
  task automatic test_done();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  // Drive one slot and note what the next cycle must show
  task automatic step(input iskp_op_e o, input logic [7:0] d);
    logic [7:0] inc;
    logic [7:0] a;
    logic we;
    logic sk;
    inc = d + INC_STEP;
    a = 8'($urandom);
    we = 1'b0;
    sk = 1'b0;
    @(negedge mclk);
    op <= o;
    mem_rdata <= d;
    mem_addr <= a;
    if (!skip_m && o == ISKP_OP_INCR_MEM_SKIP_ZERO) begin
      we = 1'b1;
      sk = (inc == ZERO_VAL);
    end
    if (!skip_m && o == ISKP_OP_INCR_TO_ACC_SKIP_ZERO) begin
      acc_m = inc;
      sk = (inc == ZERO_VAL);
    end
    if (!skip_m && o == ISKP_OP_SKIP_IF_NONZERO_TEST) begin
      sk = (d != ZERO_VAL);
    end
    skip_m = sk; // Slot after a skip is ignored
    exp_q.push_back({we, sk, sk, sk, 1'b0, acc_m, a, we ? inc : 8'h00});
  endtask : step
  // Watcher takes the oldest note each cycle
  initial begin
    logic [28:0] got;
    logic [28:0] exp_v;
    forever begin
      @(posedge mclk);
      #1;
      got = {mem_we, skip_next, dummy_cycle, busy, flags_we, accumulator_reg,
        mem_waddr, mem_we ? mem_wdata : 8'h00};
      if (exp_q.size() > 0) begin
        exp_v = exp_q.pop_front();
        cmp(got, exp_v);
      end
    end
  end
  // Random ops, wrap and zero operands mixed in, then a reset in mid-run
  initial begin
    logic [7:0] d;
    void'($urandom(7113));
    repeat (2) @(negedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 400; i++) begin
      d = 8'($urandom);
      if (i % 3 == 0) d = (i % 2) ? 8'hFF : 8'h00;
      step(iskp_op_e'($urandom_range(3, 0)), d);
    end
    step(ISKP_OP_NONE, 8'h00);
    repeat (2) @(negedge mclk);
    $display("test random_ops done");
    // Reset overrides a wrapping memory op and clears every output
    nrst <= 1'b0;
    op <= ISKP_OP_INCR_MEM_SKIP_ZERO;
    mem_rdata <= 8'hFF;
    @(negedge mclk);
    cmp({mem_we, skip_next, dummy_cycle, busy, flags_we, accumulator_reg,
      mem_waddr, mem_wdata}, {5'h00, ACC_RESET, 16'h0000});
    acc_m = ACC_RESET;
    skip_m = 1'b0;
    nrst <= 1'b1;
    op <= ISKP_OP_NONE;
    for (int i = 0; i < 40; i++) begin
      step(iskp_op_e'($urandom_range(3, 0)), (i % 4 == 0) ? 8'hFF : 8'h00);
    end
    step(ISKP_OP_NONE, 8'h00);
    repeat (2) @(negedge mclk);
    cmp(29'(exp_q.size()), 29'h00000000);
    $display("test reset_mid done");
    test_done();
  end
endmodule : tb_top
